// ---- rtl/serial_port_regs.vh ----
// Field positions, chip address and timing constants of the serial control port.
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
`define WORD_BITS 13
`define ADDR_LSB 0
`define ADDR_MSB 2
`define SEL_LSB 3
`define SEL_MSB 4
`define DATA_LSB 5
`define DATA_MSB 12
`define CHIP_ADDR 3'h5
`define SEL_GAIN 2'h0
`define SEL_POWER 2'h1
`define SEL_AUX 2'h2
`define SEL_CTRL 2'h3
`define GAIN_MSB 5
`define AUX_MSB 6
`define SYS_CLK_HZ 50000000
`define RX_CLK_MAX_HZ 10000000
`define RX_SAMPLE_BITS 12
`define GAIN_RESET 6'h00
`define GAIN_DB_RESET 5'h00
`define POWER_RESET 8'h00
`define AUX_RESET 7'h00
`define CTRL_RESET 8'h00
`endif

// ---- rtl/afe_serial_control_port.v ----
// Serial control port of the front end: word decoder and control registers.
//
// Notes on behaviour
// - Data and frame sampled on falling serial clock.
// - First three bits compared against chip address.
// - Match accepts ten bits; mismatch changes nothing.
// - Two bits after address select register.
// - Last eight bits load power and control; gain takes the low six, aux the low seven.
// - Auxiliary converter code is seven bits wide.
// - Receive samples twelve bits, clock up to 10MHz.
// - Thirteen-bit word, sent least significant first.
// - Respond only to chip address 101.
// - Select 00 gain, 01 power, 10 aux, 11 control.
// - Gain code sits in gain register bits 5:0.
`timescale 1ns/1ps
`include "serial_port_regs.vh"

module afe_serial_control_port #(
   parameter WORD_BITS = `WORD_BITS
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_ser_clk,
   input wire i_ser_data_in,
   input wire i_ser_frame_sync,
   output reg [5:0] o_rx_gain_code,
   output reg [4:0] o_rx_gain_db,
   output reg [7:0] o_power_mode,
   output reg [6:0] o_aux_dac_code,
   output reg [7:0] o_control,
   output reg o_write_strobe
);

   // Receive converter limits; that path is analog, so nothing here uses
   // them beyond recording the sample width and clock ceiling.
   localparam integer RX_SAMPLE_BITS = `RX_SAMPLE_BITS;
   localparam integer RX_CLK_MAX_HZ = `RX_CLK_MAX_HZ;
   localparam integer LAST_BIT = WORD_BITS - 1;
   localparam integer SYNC_PINS = 3;
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_SHIFT = 2'h1;
   localparam [1:0] ST_LOAD = 2'h2;

   wire [SYNC_PINS-1:0] pin_raw;
   wire [SYNC_PINS-1:0] pin_sync;
   reg ser_clk_last;
   wire ser_clk_sync;
   wire data_sync;
   wire frame_sync;
   wire fall_edge;
   wire frame_start;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [3:0] bit_count;
   reg [3:0] next_bit_count;
   reg [12:0] shift;
   reg [12:0] next_shift;
   wire [12:0] word;
   wire word_match;
   wire [1:0] word_sel;
   wire [7:0] word_data;
   genvar g;

   // Gain code to relative dB: base from top three bits, step from the rest.
   function [4:0] gain_db;
      input [5:0] code;
      reg [4:0] base;
      reg [2:0] step;
      begin
         case (code[5:3])
            3'h3: base = 5'h00;
            3'h4: base = 5'h06;
            3'h5: base = 5'h0c;
            3'h6: base = 5'h12;
            3'h7: base = 5'h18;
            default: base = 5'h00;
         endcase
         step = (code[2:0] == 3'h7) ? 3'h6 : code[2:0];
         if (code[5:3] < 3'h3) begin
            gain_db = 5'h00;
         end else begin
            gain_db = base + {2'h0, step};
         end
      end
   endfunction

   // Pin order in the synchroniser bank: clock, data, frame.
   assign pin_raw = {i_ser_frame_sync, i_ser_data_in, i_ser_clk};

   // The link clock is sampled like any other pin, so each of its phases
   // must last at least two system cycles for every edge to be seen.
   // Two flops per pin; only the second stage feeds the decoder.
   generate
      for (g = 0; g < SYNC_PINS; g = g + 1) begin : sync_bank
         reg stage_meta;
         reg stage_out;
         always @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
               stage_meta <= 1'b0;
               stage_out <= 1'b0;
            end else begin
               stage_meta <= pin_raw[g];
               stage_out <= stage_meta;
            end
         end
         assign pin_sync[g] = stage_out;
      end
   endgenerate

   assign ser_clk_sync = pin_sync[0];
   assign data_sync = pin_sync[1];
   assign frame_sync = pin_sync[2];

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ser_clk_last <= 1'b0;
      end else begin
         ser_clk_last <= ser_clk_sync;
      end
   end

   // Data and frame pass the same two stages, so at the detected falling
   // edge they show the levels present at the pin edge.
   assign fall_edge = ser_clk_last & ~ser_clk_sync;
   assign frame_start = fall_edge & frame_sync;
   // Bits arrive least significant first; the last bit lands on top.
   assign word = {data_sync, shift[12:1]};

   always @* begin
      next_state = state;
      next_bit_count = bit_count;
      next_shift = shift;
      case (state)
         ST_IDLE: begin
            if (frame_start) begin
               next_state = ST_SHIFT;
               next_bit_count = 4'h1;
               next_shift = {data_sync, 12'h000};
            end
         end
         ST_SHIFT: begin
            if (frame_start) begin
               // A frame mid-word restarts; the partial word is lost.
               next_bit_count = 4'h1;
               next_shift = {data_sync, 12'h000};
            end else if (fall_edge) begin
               next_shift = word;
               next_bit_count = bit_count + 4'h1;
               if (bit_count == LAST_BIT[3:0]) begin
                  next_state = ST_LOAD;
               end
            end
         end
         ST_LOAD: begin
            // Falling edges are far apart, but a frame here still wins.
            next_state = ST_IDLE;
            if (frame_start) begin
               next_state = ST_SHIFT;
               next_bit_count = 4'h1;
               next_shift = {data_sync, 12'h000};
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
         bit_count <= 4'h0;
         shift <= 13'h0000;
      end else begin
         state <= next_state;
         bit_count <= next_bit_count;
         shift <= next_shift;
      end
   end

   // The word is judged one cycle after its last bit, from flops only, which
   // costs a cycle of latency but keeps the compare off the sampling path.
   assign word_match = (state == ST_LOAD) &&
      (shift[`ADDR_MSB:`ADDR_LSB] == `CHIP_ADDR);
   assign word_sel = shift[`SEL_MSB:`SEL_LSB];
   assign word_data = shift[`DATA_MSB:`DATA_LSB];

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_write_strobe <= 1'b0;
         // The real part powers up undefined; zero is chosen here.
         o_rx_gain_code <= `GAIN_RESET;
         o_rx_gain_db <= `GAIN_DB_RESET;
         o_power_mode <= `POWER_RESET;
         o_aux_dac_code <= `AUX_RESET;
         o_control <= `CTRL_RESET;
      end else begin
         // A word for another address ends here with nothing written.
         o_write_strobe <= word_match;
         if (word_match) begin
            case (word_sel)
               `SEL_GAIN: begin
                  o_rx_gain_code <= word_data[`GAIN_MSB:0];
                  o_rx_gain_db <= gain_db(word_data[`GAIN_MSB:0]);
               end
               `SEL_POWER: begin
                  o_power_mode <= word_data;
               end
               `SEL_AUX: begin
                  o_aux_dac_code <= word_data[`AUX_MSB:0];
               end
               default: begin
                  o_control <= word_data;
               end
            endcase
         end
      end
   end

endmodule // afe_serial_control_port

// ---- testbench/host_ser_model.sv ----
// Host serial port model.
`timescale 1ns/1ps
module host_ser_model (
   input wire clk,
   output logic sclk = 1'b1,
   output logic fs = 1'b0,
   output logic sd = 1'b0
);
   task automatic send(input logic [12:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         fs = (i == 0);
         sd = w[i];
         repeat (4) @(negedge clk);
         sclk = 1'b0;
         repeat (4) @(negedge clk);
      end
      sclk = 1'b1;
      fs = 1'b0;
      sd = ~sd; // A released line must not look like a held bit.
   endtask
endmodule // host_ser_model

// ---- testbench/afe_serial_control_port_assertions.sv ----
// Checker for the serial control port.
`timescale 1ns/1ps
module afe_serial_control_port_assertions (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_ser_clk,
   input wire [5:0] o_rx_gain_code,
   input wire [4:0] o_rx_gain_db,
   input wire [7:0] o_power_mode,
   input wire [6:0] o_aux_dac_code,
   input wire [7:0] o_control,
   input wire o_write_strobe
);
   reg ser_prev;
   reg [3:0] since;
   wire [2:0] hi = o_rx_gain_code[5:3];
   wire [2:0] lo = o_rx_gain_code[2:0];
   wire [4:0] exp_db = (hi < 3'h3) ? 5'h0 : {2'h0, hi - 3'h3} * 5'h6
      + ((lo == 3'h7) ? 5'h6 : {2'h0, lo});
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ser_prev <= 1'b1;
         since <= 4'hf;
      end else begin
         ser_prev <= i_ser_clk;
         since <= (ser_prev && !i_ser_clk) ? 4'h0 : since + {3'h0, ~&since};
      end
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   strobe_pulse_a: assert property (o_write_strobe |=> !o_write_strobe)
      else $error("strobe too long");
   gain_hold_a: assert property ($changed(o_rx_gain_code) |-> o_write_strobe)
      else $error("gain moved");
   power_hold_a: assert property ($changed(o_power_mode) |-> o_write_strobe)
      else $error("power moved");
   aux_hold_a: assert property ($changed(o_aux_dac_code) |-> o_write_strobe)
      else $error("aux moved");
   ctrl_hold_a: assert property ($changed(o_control) |-> o_write_strobe)
      else $error("control moved");
   single_target_a: assert property ($onehot0({$changed(o_rx_gain_code),
      $changed(o_power_mode), $changed(o_aux_dac_code), $changed(o_control)}))
      else $error("two targets");
   gain_decode_a: assert property (o_rx_gain_db == exp_db)
      else $error("gain decode");
   strobe_edge_a: assert property (o_write_strobe |-> since < 4'h8)
      else $error("strobe without edge");
   cover property (o_write_strobe);
   cover property (o_rx_gain_db == 5'h1e);
   cover property ($changed(o_aux_dac_code));
endmodule // afe_serial_control_port_assertions
bind afe_serial_control_port afe_serial_control_port_assertions chk (.*);

// ---- testbench/testbench.sv ----
// Self-checking bench for the serial control port.
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire sclk, fs, sd, stb;
   wire [5:0] gain;
   wire [4:0] db;
   wire [7:0] pwr, ctl;
   wire [6:0] aux;
   int error_cnt = 0;
   int n_compared = 0;
   int n_strobe = 0;
   always #10 clk = ~clk;
   // The strobe stands one cycle, so one falling edge always sees it.
   always @(negedge clk) if (stb === 1'b1) n_strobe++;
   host_ser_model host (.clk(clk), .sclk(sclk), .fs(fs), .sd(sd));
   afe_serial_control_port uut (.i_sys_clk(clk), .i_rst(rst),
      .i_ser_clk(sclk), .i_ser_data_in(sd), .i_ser_frame_sync(fs),
      .o_rx_gain_code(gain), .o_rx_gain_db(db), .o_power_mode(pwr),
      .o_aux_dac_code(aux), .o_control(ctl), .o_write_strobe(stb));
   task chk(input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [1:0] s, input logic [7:0] d);
      host.send({d, s, a}, 13);
      repeat (6) @(negedge clk);
   endtask
   task t_regs;
      int s0;
      s0 = n_strobe;
      for (int s = 0; s < 4; s++) wr(3'h5, 2'(s), 8'hc3 ^ 8'(s));
      chk(8'(n_strobe - s0), 8'h04);
      chk({2'h0, gain}, 8'h03);
      chk(pwr, 8'hc2);
      chk({1'b0, aux}, 8'h41);
      chk(ctl, 8'hc0);
      $display("regs done");
   endtask
   task t_addr;
      int s0;
      s0 = n_strobe;
      for (int a = 0; a < 8; a++) if (a != 5) wr(3'(a), 2'h3, 8'h5a);
      chk(ctl, 8'hc0);
      chk(8'(n_strobe - s0), 8'h00);
      $display("addr done");
   endtask
   task t_gain;
      logic [5:0] c[6];
      logic [4:0] e[6];
      c = '{6'h17, 6'h1e, 6'h20, 6'h2b, 6'h38, 6'h3f};
      e = '{5'h00, 5'h06, 5'h06, 5'h0f, 5'h18, 5'h1e};
      for (int i = 0; i < 6; i++) begin
         wr(3'h5, 2'h0, {2'h0, c[i]});
         chk({2'h0, gain}, {2'h0, c[i]});
         chk({3'h0, db}, {3'h0, e[i]});
      end
      $display("gain done");
   endtask
   task t_restart;
      host.send(13'h00d, 6);
      repeat (2) @(negedge clk);
      wr(3'h5, 2'h1, 8'h55);
      chk(pwr, 8'h55);
      $display("restart done");
   endtask
   task results;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      t_regs;
      t_addr;
      t_gain;
      t_restart;
      results;
   end
   initial begin
      #1000000;
      error_cnt++;
      results;
   end
endmodule // testbench
